/* File: design/rqz_align.sv */
// Binary point aligner: extends a fixed-point word and shifts its point
`timescale 1ns/1ps
`default_nettype none
module rqz_align #(
    parameter int IN_W      = 8,
    parameter int IN_F      = 0,
    parameter int OUT_W     = 16,
    parameter int OUT_F     = 0,
    parameter bit IS_SIGNED = 1'b1
) (
    // Word in
    input  wire logic [IN_W-1:0]  val_in,
    // Aligned word out
    output logic      [OUT_W-1:0] val_out
);
    logic [OUT_W-1:0] ext;
    logic             fill;

    always_comb
    begin
        fill = IS_SIGNED & val_in[IN_W-1];
        ext  = {{(OUT_W-IN_W){fill}}, val_in};
    end

    // Point shift is a constant, so this is only wiring
    assign val_out = ext << (OUT_F - IN_F);
endmodule
`default_nettype wire

/* File: design/rqz_defines.svh */
// Register map and field constants of the fixed-point requantizer
`ifndef RQZ_DEFINES_SVH
`define RQZ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RQZ_ADDR_W      8
`define RQZ_CTRL_OFS    8'h00
`define RQZ_STATUS_OFS  8'h04
`define RQZ_RESULT_OFS  8'h08

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RQZ_QMODE_LSB   0
`define RQZ_QMODE_MSB   2
`define RQZ_OMODE_LSB   4
`define RQZ_OMODE_MSB   6
`define RQZ_STS_OVF     0
`define RQZ_STS_INEXACT 1

`endif

/* File: design/rqz_out_reg.sv */
// Output register of the requantizer: word, valid and flags
`timescale 1ns/1ps
`default_nettype none
module rqz_out_reg #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk_sys_in,
    input  wire logic         sys_rst_in,
    // Captured values
    input  wire logic         load_in,
    input  wire logic [W-1:0] word_in,
    input  wire logic         ovf_in,
    input  wire logic         inexact_in,
    // Held values
    output logic              valid_out,
    output logic      [W-1:0] word_out,
    output logic              ovf_out,
    output logic              inexact_out
);
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            valid_out <= 1'b0;
        else
            valid_out <= load_in;
    end

    // Word holds its last value between loads so software can read it
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            word_out    <= '0;
            ovf_out     <= 1'b0;
            inexact_out <= 1'b0;
        end
        else if (load_in)
        begin
            word_out    <= word_in;
            ovf_out     <= ovf_in;
            inexact_out <= inexact_in;
        end
    end
endmodule
`default_nettype wire

/* File: design/rqz_pkg.sv */
// Types shared by the fixed-point requantizer
package rqz_pkg;

    // ------------------------------------------------------------------
    // Quantization modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        truncate_mode             = 3'h0,
        truncate_toward_zero_mode = 3'h1,
        round_plus_inf_mode       = 3'h2,
        round_toward_zero_mode    = 3'h3,
        round_minus_inf_mode      = 3'h4,
        round_away_mode           = 3'h5,
        convergent_round_mode     = 3'h6
    } rqz_qmode_e;

    // ------------------------------------------------------------------
    // Overflow modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        modulo_wrap_mode          = 3'h0,
        clamp_mode                = 3'h1,
        clamp_to_zero_mode        = 3'h2,
        symmetric_clamp_mode      = 3'h3,
        sign_magnitude_wrap_mode  = 3'h4
    } rqz_omode_e;

endpackage

/* File: design/rqz_requant.sv */
// Fixed-point requantizer: align, add, round, overflow, APB registers
`timescale 1ns/1ps
`default_nettype none
`include "rqz_defines.svh"
module rqz_requant #(
    parameter int                  A_W        = 10,
    parameter int                  A_F        = 5,
    parameter int                  B_W        = 12,
    parameter int                  B_F        = 1,
    parameter bit                  IN_SIGNED  = 1'b1,
    parameter int                  OUT_W      = 8,
    parameter int                  INT_W      = 4,
    parameter bit                  OUT_SIGNED = 1'b1,
    parameter rqz_pkg::rqz_qmode_e QMODE      = rqz_pkg::truncate_mode,
    parameter rqz_pkg::rqz_omode_e OMODE      = rqz_pkg::modulo_wrap_mode,
    parameter int                  SAT_N      = 0
) (
    // Clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   sys_rst_in,
    // Operands from the upstream datapath
    input  wire logic [A_W-1:0]         op_a_in,
    input  wire logic [B_W-1:0]         op_b_in,
    input  wire logic                   op_valid_in,
    // Requantized result
    output logic      [OUT_W-1:0]       res_word_out,
    output logic                        res_valid_out,
    output logic                        res_ovf_out,
    output logic                        res_inexact_out,
    // APB slave
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [`RQZ_ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]            pwdata_in,
    output logic      [31:0]            prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out
);
    import rqz_pkg::*;

    // ------------------------------------------------------------------
    // Working widths
    // ------------------------------------------------------------------
    localparam int F_W  = OUT_W - INT_W;
    localparam int AI   = A_W - A_F;
    localparam int BI   = B_W - B_F;
    localparam int CF   = (A_F > B_F) ? A_F : B_F;
    localparam int CI   = ((AI > BI) ? AI : BI) + 1;
    localparam int SW   = CI + CF;
    // Two spare integer bits keep rounding carry and sign unambiguous
    localparam int XF   = (CF > F_W) ? CF : F_W;
    localparam int XI   = ((CI > INT_W) ? CI : INT_W) + 2;
    localparam int XW   = XI + XF;
    localparam int D    = XF - F_W;
    localparam int QW   = XI + F_W;

    // ------------------------------------------------------------------
    // Alignment and sum
    // ------------------------------------------------------------------
    logic [SW-1:0] a_al;
    logic [SW-1:0] b_al;
    logic [SW-1:0] sum;
    logic [XW-1:0] v;

    rqz_align #(
        .IN_W      (A_W),
        .IN_F      (A_F),
        .OUT_W     (SW),
        .OUT_F     (CF),
        .IS_SIGNED (IN_SIGNED)
    ) u_align_a (
        .val_in  (op_a_in),
        .val_out (a_al)
    );

    rqz_align #(
        .IN_W      (B_W),
        .IN_F      (B_F),
        .OUT_W     (SW),
        .OUT_F     (CF),
        .IS_SIGNED (IN_SIGNED)
    ) u_align_b (
        .val_in  (op_b_in),
        .val_out (b_al)
    );

    // Carry cannot escape: CI holds one bit of growth
    assign sum = a_al + b_al;

    rqz_align #(
        .IN_W      (SW),
        .IN_F      (CF),
        .OUT_W     (XW),
        .OUT_F     (XF),
        .IS_SIGNED (IN_SIGNED)
    ) u_align_sum (
        .val_in  (sum),
        .val_out (v)
    );

    // ------------------------------------------------------------------
    // Mode and status registers
    // ------------------------------------------------------------------
    rqz_qmode_e qmode;
    rqz_omode_e omode;
    logic       sts_ovf;
    logic       sts_inexact;

    // ------------------------------------------------------------------
    // Quantization, done before overflow
    // ------------------------------------------------------------------
    logic [QW-1:0] q;
    logic [QW-1:0] kept;
    logic          inexact;
    logic          q_add;

    generate
        if (D > 0)
        begin : g_quant
            logic       half;
            logic       rest;
            logic       neg_v;
            logic [D:0] low_x;

            always_comb
            begin
                low_x = {v[D-1:0], 1'b0};
                kept  = v[XW-1:D];
                half  = v[D-1];
                rest  = |low_x[D-1:0];
                neg_v = v[XW-1];
                inexact = half | rest;
                case (qmode)
                    truncate_mode:             q_add = 1'b0;
                    truncate_toward_zero_mode: q_add = neg_v & inexact;
                    round_plus_inf_mode:       q_add = half;
                    round_toward_zero_mode:    q_add = half & (rest | neg_v);
                    round_minus_inf_mode:      q_add = half & rest;
                    round_away_mode:           q_add = half & (rest | ~neg_v);
                    convergent_round_mode:     q_add = half & (rest | kept[0]);
                    default:                   q_add = 1'b0;
                endcase
                q = kept + {{(QW-1){1'b0}}, q_add};
            end

            logic [XW-1:0] q_err;
            logic [XW-1:0] half_unit;
            assign q_err     = {q, {D{1'b0}}} - v;
            assign half_unit = {{(XW-D){1'b0}}, 1'b1, {(D-1){1'b0}}};

            property p_nearest_up;
                @(posedge clk_sys_in) disable iff (sys_rst_in)
                (qmode == round_plus_inf_mode) |->
                    ($signed(q_err) <= $signed(half_unit)) &&
                    ($signed(q_err) > -$signed(half_unit));
            endproperty
            a_nearest_up: assert property (p_nearest_up)
                else $error("Round to plus infinity not nearest");
        end
        else
        begin : g_noquant
            always_comb
            begin
                kept    = v;
                q       = v;
                q_add   = 1'b0;
                inexact = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Overflow detection on the rounded value
    // ------------------------------------------------------------------
    logic             q_neg;
    logic             fits;
    logic             ovf;
    logic [OUT_W-1:0] low;
    logic [OUT_W-1:0] max_v;
    logic [OUT_W-1:0] min_v;
    logic [OUT_W-1:0] sym_min_v;
    logic [OUT_W-1:0] sat_mask;

    always_comb
    begin
        q_neg = q[QW-1];
        low   = q[OUT_W-1:0];
        if (OUT_SIGNED)
            fits = (&q[QW-1:OUT_W-1]) | ~(|q[QW-1:OUT_W-1]);
        else
            fits = ~(|q[QW-1:OUT_W]);
        ovf = ~fits;
    end

    always_comb
    begin
        max_v     = {OUT_SIGNED ? 1'b0 : 1'b1, {(OUT_W-1){1'b1}}};
        min_v     = {OUT_SIGNED ? 1'b1 : 1'b0, {(OUT_W-1){1'b0}}};
        sym_min_v = OUT_SIGNED ? (min_v | {{(OUT_W-1){1'b0}}, 1'b1}) : '0;
        for (int k = 0; k < OUT_W; k++)
            sat_mask[k] = (k >= OUT_W - SAT_N);
    end

    // ------------------------------------------------------------------
    // Overflow handling
    // ------------------------------------------------------------------
    logic [OUT_W-1:0] wrap_word;
    logic [OUT_W-1:0] sm_word;
    logic             sm_sign;
    logic [OUT_W-1:0] next_word;

    always_comb
    begin
        wrap_word = low;
        if (SAT_N > 0)
        begin
            wrap_word = low | sat_mask;
            if (OUT_SIGNED)
                wrap_word[OUT_W-1] = q_neg;
        end
        sm_sign = (SAT_N > 0) ? q_neg : q[OUT_W];
        sm_word = {sm_sign, low[OUT_W-2:0]};
        if (sm_sign != low[OUT_W-1])
            sm_word = {sm_sign, ~low[OUT_W-2:0]};
        if (SAT_N > 0)
        begin
            sm_word = sm_word | sat_mask;
            sm_word[OUT_W-1] = sm_sign;
        end
    end

    always_comb
    begin
        next_word = low;
        if (ovf)
        begin
            case (omode)
                clamp_mode:
                    next_word = q_neg ? min_v : max_v;
                clamp_to_zero_mode:
                    next_word = '0;
                symmetric_clamp_mode:
                    next_word = q_neg ? sym_min_v : max_v;
                sign_magnitude_wrap_mode:
                    next_word = sm_word;
                modulo_wrap_mode:
                    next_word = wrap_word;
                default:
                    next_word = wrap_word;
            endcase
        end
    end

    rqz_out_reg #(
        .W (OUT_W)
    ) u_out (
        .clk_sys_in  (clk_sys_in),
        .sys_rst_in  (sys_rst_in),
        .load_in     (op_valid_in),
        .word_in     (next_word),
        .ovf_in      (ovf),
        .inexact_in  (inexact),
        .valid_out   (res_valid_out),
        .word_out    (res_word_out),
        .ovf_out     (res_ovf_out),
        .inexact_out (res_inexact_out)
    );

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic        wr_en;
    logic        setup;
    logic [31:0] ctrl_rd;
    logic [31:0] sts_rd;
    logic [31:0] res_rd;

    // Zero wait states; read data is captured in the setup cycle
    assign pready_out = 1'b1;
    assign setup      = psel_in & ~penable_in;
    assign wr_en      = psel_in & penable_in & pwrite_in;

    always_comb
    begin
        ctrl_rd = '0;
        ctrl_rd[`RQZ_QMODE_MSB:`RQZ_QMODE_LSB] = qmode;
        ctrl_rd[`RQZ_OMODE_MSB:`RQZ_OMODE_LSB] = omode;
        sts_rd = '0;
        sts_rd[`RQZ_STS_OVF]     = sts_ovf;
        sts_rd[`RQZ_STS_INEXACT] = sts_inexact;
        res_rd = '0;
        res_rd[OUT_W-1:0] = res_word_out;
    end

    // Modes reset to the elaborated choice; software may retune later
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            qmode <= QMODE;
            omode <= OMODE;
        end
        else if (wr_en && paddr_in == `RQZ_CTRL_OFS)
        begin
            qmode <= rqz_qmode_e'(pwdata_in[`RQZ_QMODE_MSB:`RQZ_QMODE_LSB]);
            omode <= rqz_omode_e'(pwdata_in[`RQZ_OMODE_MSB:`RQZ_OMODE_LSB]);
        end
    end

    // Sticky flags, write one to clear; a new event beats the clear
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sts_ovf     <= 1'b0;
            sts_inexact <= 1'b0;
        end
        else
        begin
            if (op_valid_in && ovf)
                sts_ovf <= 1'b1;
            else if (wr_en && paddr_in == `RQZ_STATUS_OFS &&
                     pwdata_in[`RQZ_STS_OVF])
                sts_ovf <= 1'b0;
            if (op_valid_in && inexact)
                sts_inexact <= 1'b1;
            else if (wr_en && paddr_in == `RQZ_STATUS_OFS &&
                     pwdata_in[`RQZ_STS_INEXACT])
                sts_inexact <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
        end
        else if (setup)
        begin
            pslverr_out <= 1'b0;
            case (paddr_in)
                `RQZ_CTRL_OFS:   prdata_out <= ctrl_rd;
                `RQZ_STATUS_OFS: prdata_out <= sts_rd;
                `RQZ_RESULT_OFS: prdata_out <= res_rd;
                default:
                begin
                    prdata_out  <= '0;
                    pslverr_out <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_fit_pass;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (op_valid_in && !ovf) |=> res_valid_out && !res_ovf_out &&
            (res_word_out == $past(low));
    endproperty
    a_fit_pass: assert property (p_fit_pass)
        else $error("In-range value not passed through");

    property p_clamp_hi;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (op_valid_in && ovf && !q_neg && omode == clamp_mode)
            |=> res_word_out == max_v;
    endproperty
    a_clamp_hi: assert property (p_clamp_hi)
        else $error("Positive overflow not clamped to maximum");

    property p_clamp_lo;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (op_valid_in && ovf && q_neg && omode == clamp_mode)
            |=> res_word_out == (OUT_SIGNED ? min_v : '0);
    endproperty
    a_clamp_lo: assert property (p_clamp_lo)
        else $error("Negative overflow not clamped to minimum");

    property p_clamp_zero;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (op_valid_in && ovf && omode == clamp_to_zero_mode)
            |=> res_ovf_out && res_word_out == '0;
    endproperty
    a_clamp_zero: assert property (p_clamp_zero)
        else $error("Overflow not forced to zero");

    property p_sym_lo;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (op_valid_in && ovf && q_neg && omode == symmetric_clamp_mode)
            |=> res_word_out == (OUT_SIGNED ? ~max_v + 1'b1 : '0);
    endproperty
    a_sym_lo: assert property (p_sym_lo)
        else $error("Symmetric clamp gave wrong negative limit");

    property p_wrap_mod;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (op_valid_in && SAT_N == 0 && omode == modulo_wrap_mode)
            |=> res_word_out == $past(q[OUT_W-1:0]);
    endproperty
    a_wrap_mod: assert property (p_wrap_mod)
        else $error("Wrap did not keep low bits");

    property p_trunc_floor;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (qmode == truncate_mode) |-> q == (v >> D);
    endproperty
    a_trunc_floor: assert property (p_trunc_floor)
        else $error("Truncation did not drop surplus bits");

    property p_sticky_ovf;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (op_valid_in && ovf) |=> sts_ovf ##1 (sts_ovf || $past(wr_en));
    endproperty
    a_sticky_ovf: assert property (p_sticky_ovf)
        else $error("Overflow event lost from status");

    property p_sm_sign;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (op_valid_in && ovf && SAT_N == 0 &&
         omode == sign_magnitude_wrap_mode)
            |=> res_word_out[OUT_W-1] == $past(q[OUT_W]);
    endproperty
    a_sm_sign: assert property (p_sm_sign)
        else $error("Sign-magnitude wrap sign not from dropped bit");
endmodule
`default_nettype wire

/* File: tb/rqz_src.sv */
// Upstream datapath model feeding operand pairs to the requantizer
`timescale 1ns/1ps
`default_nettype none
module rqz_src (
    // Clock
    input  wire logic        clk_sys_in,
    // Operand pair
    output logic      [9:0]  op_a_out,
    output logic      [11:0] op_b_out,
    output logic             op_valid_out
);
    initial
    begin
        op_a_out = 10'h000;
        op_b_out = 12'h000;
        op_valid_out = 1'b0;
    end
    // Operands carry unlike fraction widths on purpose
    task automatic send(input logic [9:0] a, input logic [11:0] b);
        op_a_out <= a;
        op_b_out <= b;
        op_valid_out <= 1'b1;
        @(posedge clk_sys_in);
    endtask
    // Idle lines flip so a stale operand can never pass as fresh
    task automatic idle();
        op_a_out <= ~op_a_out;
        op_b_out <= ~op_b_out;
        op_valid_out <= 1'b0;
        @(posedge clk_sys_in);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the requantizer: all modes and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "rqz_defines.svh"
module tb;
    import rqz_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [9:0]  op_a;
    logic [11:0] op_b;
    logic        op_valid, res_valid, res_ovf, res_inx, pready, pslverr, er;
    logic [7:0]  res_word;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [9:0]  exp_q[$];
    logic [9:0]  va[8] = '{10'h2, 10'h3fe, 10'h3, 10'h3ff, 10'h6, 10'h0,
                           10'h0, 10'h1e};
    logic [11:0] vb[8] = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h026,
                           12'hfda, 12'h00f};
    int          fail_count = 0;
    int          checked = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    rqz_src src (.clk_sys_in(clk_sys_in), .op_a_out(op_a), .op_b_out(op_b),
        .op_valid_out(op_valid));
    rqz_requant #(.A_W(10), .A_F(6), .OUT_W(8), .INT_W(4))
    uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .op_a_in(op_a),
        .op_b_in(op_b), .op_valid_in(op_valid), .res_word_out(res_word),
        .res_valid_out(res_valid), .res_ovf_out(res_ovf),
        .res_inexact_out(res_inx), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] ex,
        input logic [31:0] sn);
        checked++;
        if (sn !== ex)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, sn);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys_in);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            fail_count++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    // Expected word from exact sum: two fraction bits are dropped here
    function automatic logic [9:0] ref_res(input logic [9:0] a,
        input logic [11:0] b, input int q, input int o);
        int s, f, r, v;
        logic u;
        logic [7:0] w;
        s = int'($signed(a)) + int'($signed(b)) * 32;
        f = s >>> 2;
        r = s & 3;
        case (q)
            1: u = s < 0 && r != 0;
            2: u = r >= 2;
            3: u = r == 3 || (r == 2 && s < 0);
            4: u = r == 3;
            5: u = r == 3 || (r == 2 && s >= 0);
            6: u = r == 3 || (r == 2 && f[0]);
            default: u = 1'b0;
        endcase
        v = f + int'(u);
        w = v[7:0];
        if (v > 127 || v < -128)
            case (o)
                1: w = v > 0 ? 8'h7f : 8'h80;
                2: w = 8'h00;
                3: w = v > 0 ? 8'h7f : 8'h81;
                4: w = {v[8], v[6:0] ^ {7{v[8] ^ v[7]}}};
                default: ;
            endcase
        return {v > 127 || v < -128, r != 0, w};
    endfunction
    // Any extra or missing valid pulse shows up as a queue mismatch
    always @(posedge clk_sys_in)
        if (res_valid === 1'b1)
            check("result", 32'(exp_q.pop_front()),
                {22'h0, res_ovf, res_inx, res_word});
    initial
    begin
        repeat (4) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        apb(1'b0, `RQZ_CTRL_OFS, 32'h0);
        check("ctrl reset", 32'({modulo_wrap_mode, 1'b0, truncate_mode}),
            rd);
        // Spare codes too: they must act as truncation and as wrap
        for (int o = 0; o < 8; o++)
            for (int q = 0; q < 8; q++)
            begin
                apb(1'b1, `RQZ_CTRL_OFS, 32'(o * 16 + q));
                apb(1'b0, `RQZ_CTRL_OFS, 32'h0);
                check("ctrl", 32'(o * 16 + q), rd);
                for (int i = 0; i < 8; i++)
                begin
                    exp_q.push_back(ref_res(va[i], vb[i], q, o));
                    src.send(va[i], vb[i]);
                end
                src.idle();
                repeat (2) @(posedge clk_sys_in);
            end
        check("pending", 32'h0, 32'(exp_q.size()));
        apb(1'b0, `RQZ_STATUS_OFS, 32'h0);
        check("status", 32'h3, rd);
        apb(1'b1, `RQZ_STATUS_OFS, 32'h3);
        apb(1'b0, `RQZ_STATUS_OFS, 32'h0);
        check("status clear", 32'h0, rd);
        apb(1'b1, `RQZ_RESULT_OFS, 32'h0);
        apb(1'b0, `RQZ_RESULT_OFS, 32'h0);
        check("result reg", 32'(ref_res(va[7], vb[7], 7, 7) & 10'h0ff),
            rd);
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        check("unmapped err", 32'h1, {31'h0, er});
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped err", 32'h1, {31'h0, er});
        check("unmapped data", 32'h0, rd);
        apb(1'b0, `RQZ_CTRL_OFS, 32'h0);
        check("ctrl kept", 32'h77, rd);
        give_verdict();
    end
endmodule
`default_nettype wire
